// File: bdpr_pkg.sv
/*
 Package for the bridge data parity reporting block: shared constants,
 the per-side activity type and the functional notes.
 Assumes nothing of its surroundings; imported by every design file.
*/
// Functional notes
// RULE_01 - Primary master bit only while primary master
// RULE_02 - Primary master bit needs primary response enable
// RULE_03 - Primary bit on sampled error line or own detect
// RULE_04 - Secondary master bit only while secondary master
// RULE_05 - Secondary master bit needs secondary response enable
// RULE_06 - Secondary bit on sampled line or own detect
// RULE_07 - Primary error output only as write target/read initiator
// RULE_08 - Primary error output needs primary response enable
// RULE_09 - Primary output on own error or downstream delayed write
// RULE_10 - Secondary output only as write target/read initiator
// RULE_11 - Secondary output needs secondary response enable
// RULE_12 - Secondary output on own error or upstream delayed write
// RULE_13 - Parity error lines active low, idle high
`default_nettype none
package bdpr_pkg;

   // Reset values
   localparam logic RST_STATUS  = 1'b0;    // Sticky status bits clear
   localparam logic RST_LINE_N  = 1'b1;    // Error line released high
   localparam logic RST_OE      = 1'b0;    // Not driving after reset
   localparam logic RST_SYNC    = 1'b1;    // Synchronisers idle high

   // Synchroniser depth for pin inputs
   localparam int   SYNC_STAGES = 2;

   // Drive phase of one parity error line
   typedef enum logic [1:0] {
      BDPR_IDLE,
      BDPR_ASSERT,
      BDPR_RELEASE
   } bdpr_drive_t;

endpackage
`default_nettype wire

// File: bdpr_sync.sv
/*
 Two flip-flop synchroniser for one active-low pin input.
 Assumes mclk domain; input from a pin, idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module bdpr_sync
   import bdpr_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset_n,
   // Pin side
   input  wire logic pin_n,
   // Synchronised side
   output logic      sync_n
);

   logic meta;        // First stage, read only by second stage
   logic next_meta;   // Next first stage
   logic next_sync_n; // Next second stage

   ////////////////////////////////////////////////////////////////////////
   // Next values
   always_comb begin
      next_meta   = pin_n;
      next_sync_n = meta;
   end

   // Registers; constant on reset only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta   <= RST_SYNC;
         sync_n <= RST_SYNC;
      end else begin
         meta   <= next_meta;
         sync_n <= next_sync_n;
      end
   end

endmodule
`default_nettype wire

// File: bdpr_perr_drv.sv
/*
 Driver for one parity error line of the bridge (active low, driven).
 Assumes requests arrive from mclk logic, already qualified.
 Drives low one cycle per report, then high one cycle before releasing,
 as the bus expects a driven high before tri-state.
*/
`timescale 1ns/1ps
`default_nettype none
module bdpr_perr_drv
   import bdpr_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset_n,
   // Control
   input  wire logic allowed,   // Bridge in a reporting role
   input  wire logic report,    // Qualified error this cycle
   // Pin side
   output logic      line_out_n,
   output logic      line_oe
);

   bdpr_drive_t state;       // Drive phase
   bdpr_drive_t next_state;  // Next drive phase
   logic        next_out_n;  // Next line level
   logic        next_oe;     // Next enable

   ////////////////////////////////////////////////////////////////////////
   // Next state and outputs
   always_comb begin
      next_state = state;
      next_out_n = RST_LINE_N;
      next_oe    = RST_OE;
      unique case (state)
         BDPR_IDLE, BDPR_RELEASE: begin
            // Only report while in a legal role
            if (allowed && report) begin
               next_state = BDPR_ASSERT;
               next_out_n = 1'b0;                 // RULE_13
               next_oe    = 1'b1;
            end else begin
               next_state = BDPR_IDLE;
            end
         end
         BDPR_ASSERT: begin
            // Back to back errors keep the line low
            if (allowed && report) begin
               next_out_n = 1'b0;                 // RULE_13
               next_oe    = 1'b1;
            end else begin
               // Drive high for one cycle, avoids slow pull-up edge
               next_state = BDPR_RELEASE;
               next_out_n = 1'b1;                 // RULE_13
               next_oe    = 1'b1;
            end
         end
      endcase
   end

   // Registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= BDPR_IDLE;
         line_out_n <= RST_LINE_N;
         line_oe    <= RST_OE;
      end else begin
         state      <= next_state;
         line_out_n <= next_out_n;
         line_oe    <= next_oe;
      end
   end

endmodule
`default_nettype wire

// File: bdpr_top.sv
/*
 Bridge data parity reporting: master data parity detected status bits
 for both interfaces and both parity error line drivers.
 Assumes the bridge core gives role and detect strobes on mclk, and that
 both bus parity error lines arrive as pins (synchronised here).
 Status bits are sticky; software clears them by a clear strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module bdpr_top
   import bdpr_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset_n,
   // Configuration
   input  wire logic pri_perr_resp_en,   // Primary command register bit
   input  wire logic sec_perr_resp_en,   // Bridge control register bit
   // Primary bus role and detect, from core
   input  wire logic pri_master,         // Bridge is master on primary
   input  wire logic pri_write_target,   // Target of a write
   input  wire logic pri_read_init,      // Initiator of a read
   input  wire logic pri_data_perr,      // Own data parity detect
   input  wire logic pri_dly_wr_done,    // Upstream delayed write done
   // Secondary bus role and detect, from core
   input  wire logic sec_master,
   input  wire logic sec_write_target,
   input  wire logic sec_read_init,
   input  wire logic sec_data_perr,
   input  wire logic sec_dly_wr_done,    // Downstream delayed write done
   // Status clear strobes
   input  wire logic pri_mdpd_clear,
   input  wire logic sec_mdpd_clear,
   // Status out
   output logic      pri_mdpd,           // Primary master parity detected
   output logic      sec_mdpd,           // Secondary master parity detected
   // Primary parity error pin
   input  wire logic primary_parity_error_n_in,
   output logic      primary_parity_error_n_out,
   output logic      primary_parity_error_n_oe,
   // Secondary parity error pin
   input  wire logic secondary_parity_error_n_in,
   output logic      secondary_parity_error_n_out,
   output logic      secondary_parity_error_n_oe
);

   logic pri_line_n;     // Synchronised primary line
   logic sec_line_n;     // Synchronised secondary line
   logic pri_own_n;      // Our own drive, delayed to match sync
   logic sec_own_n;
   logic pri_own_d;
   logic sec_own_d;
   logic next_pri_own_d;
   logic next_sec_own_d;
   logic next_pri_own_n;
   logic next_sec_own_n;
   logic pri_seen;       // Line low from another driver
   logic sec_seen;
   logic pri_set;        // Status set terms
   logic sec_set;
   logic pri_allow;      // Reporting role per side
   logic sec_allow;
   logic pri_report;     // Qualified report per side
   logic sec_report;
   logic next_pri_mdpd;
   logic next_sec_mdpd;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   bdpr_sync u_pri_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_n   (primary_parity_error_n_in),
      .sync_n  (pri_line_n)
   );

   bdpr_sync u_sec_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_n   (secondary_parity_error_n_in),
      .sync_n  (sec_line_n)
   );

   ////////////////////////////////////////////////////////////////////////
   // Own drive delayed two cycles, to line up with the synchronised pin
   always_comb begin
      next_pri_own_d = primary_parity_error_n_oe
                       && !primary_parity_error_n_out;
      next_sec_own_d = secondary_parity_error_n_oe
                       && !secondary_parity_error_n_out;
      next_pri_own_n = !pri_own_d;
      next_sec_own_n = !sec_own_d;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pri_own_d <= RST_OE;
         sec_own_d <= RST_OE;
         pri_own_n <= RST_LINE_N;
         sec_own_n <= RST_LINE_N;
      end else begin
         pri_own_d <= next_pri_own_d;
         sec_own_d <= next_sec_own_d;
         pri_own_n <= next_pri_own_n;
         sec_own_n <= next_sec_own_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line seen low; our own echo does not count as a report
   always_comb begin
      pri_seen = !pri_line_n && pri_own_n;             // RULE_13
      sec_seen = !sec_line_n && sec_own_n;             // RULE_13
   end

   ////////////////////////////////////////////////////////////////////////
   // Master data parity detected status bits
   always_comb begin
      pri_set = pri_master                             // RULE_01
                && pri_perr_resp_en                    // RULE_02
                && (pri_seen || pri_data_perr);        // RULE_03
      sec_set = sec_master                             // RULE_04
                && sec_perr_resp_en                    // RULE_05
                && (sec_seen || sec_data_perr);        // RULE_06
      // Set wins over a clear in the same cycle
      next_pri_mdpd = pri_set || (pri_mdpd && !pri_mdpd_clear);
      next_sec_mdpd = sec_set || (sec_mdpd && !sec_mdpd_clear);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pri_mdpd <= RST_STATUS;
         sec_mdpd <= RST_STATUS;
      end else begin
         pri_mdpd <= next_pri_mdpd;
         sec_mdpd <= next_sec_mdpd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reporting roles and causes for the error line drivers.
   // The forwarded case uses the other bus line seen during the delayed
   // write completion; the core must hold done over that data phase.
   always_comb begin
      pri_allow  = (pri_write_target || pri_read_init)   // RULE_07
                   && pri_perr_resp_en;                  // RULE_08
      sec_allow  = (sec_write_target || sec_read_init)   // RULE_10
                   && sec_perr_resp_en;                  // RULE_11
      pri_report = pri_data_perr                         // RULE_09
                   || (sec_dly_wr_done && sec_seen);     // RULE_09
      sec_report = sec_data_perr                         // RULE_12
                   || (pri_dly_wr_done && pri_seen);     // RULE_12
   end

   bdpr_perr_drv u_pri_drv (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .allowed    (pri_allow),
      .report     (pri_report),
      .line_out_n (primary_parity_error_n_out),
      .line_oe    (primary_parity_error_n_oe)
   );

   bdpr_perr_drv u_sec_drv (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .allowed    (sec_allow),
      .report     (sec_report),
      .line_out_n (secondary_parity_error_n_out),
      .line_oe    (secondary_parity_error_n_oe)
   );

endmodule
`default_nettype wire

// File: bdpr_asserts.sv
/*
 Checker for bdpr_top: causes of status sets and line driver phases.
 Assumes a bind onto bdpr_top; one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bdpr_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Enables, roles and own detects
   input wire logic pri_perr_resp_en,
   input wire logic sec_perr_resp_en,
   input wire logic pri_master,
   input wire logic sec_master,
   input wire logic pri_write_target,
   input wire logic sec_write_target,
   input wire logic pri_read_init,
   input wire logic sec_read_init,
   input wire logic pri_data_perr,
   input wire logic sec_data_perr,
   // Watched outputs
   input wire logic pri_mdpd,
   input wire logic sec_mdpd,
   input wire logic primary_parity_error_n_out,
   input wire logic primary_parity_error_n_oe,
   input wire logic secondary_parity_error_n_out,
   input wire logic secondary_parity_error_n_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Reporting role with enable, per side
   wire logic p_ok = pri_perr_resp_en & (pri_write_target | pri_read_init);
   wire logic s_ok = sec_perr_resp_en & (sec_write_target | sec_read_init);
   wire logic p_oe = primary_parity_error_n_oe;
   wire logic s_oe = secondary_parity_error_n_oe;
   // Driver phases: pulled low, then parked high before release
   sequence p_low;  p_oe & !primary_parity_error_n_out;   endsequence
   sequence p_park; p_oe & primary_parity_error_n_out;    endsequence
   sequence s_low;  s_oe & !secondary_parity_error_n_out; endsequence
   sequence s_park; s_oe & secondary_parity_error_n_out;  endsequence
   //////////////////////////////////////////////////////////////
   a_pri_set_cause:
   assert property ($rose(pri_mdpd) |-> $past(pri_master & pri_perr_resp_en))
      else $error("pri_mdpd set without role");
   a_sec_set_cause:
   assert property ($rose(sec_mdpd) |-> $past(sec_master & sec_perr_resp_en))
      else $error("sec_mdpd set without role");
   a_pri_own_set:
   assert property (pri_master & pri_perr_resp_en & pri_data_perr |=> pri_mdpd)
      else $error("pri_mdpd missed own detect");
   a_sec_own_set:
   assert property (sec_master & sec_perr_resp_en & sec_data_perr |=> sec_mdpd)
      else $error("sec_mdpd missed own detect");
   a_pri_low_cause:
   assert property (p_low |-> $past(p_ok)) else $error("pri line low bad");
   a_sec_low_cause:
   assert property (s_low |-> $past(s_ok)) else $error("sec line low bad");
   a_pri_report:
   assert property (p_ok & pri_data_perr |=> p_low)
      else $error("pri report missed");
   a_sec_report:
   assert property (s_ok & sec_data_perr |=> s_low)
      else $error("sec report missed");
   a_pri_park:
   assert property (p_low ##1 p_park |=> !p_oe | !primary_parity_error_n_out)
      else $error("pri park too long");
   a_sec_park:
   assert property (s_low ##1 s_park |=> !s_oe | !secondary_parity_error_n_out)
      else $error("sec park too long");
endmodule
`default_nettype wire
bind bdpr_top bdpr_asserts bdpr_asserts_inst (
   .mclk                         (mclk),
   .reset_n                      (reset_n),
   .pri_perr_resp_en             (pri_perr_resp_en),
   .sec_perr_resp_en             (sec_perr_resp_en),
   .pri_master                   (pri_master),
   .sec_master                   (sec_master),
   .pri_write_target             (pri_write_target),
   .sec_write_target             (sec_write_target),
   .pri_read_init                (pri_read_init),
   .sec_read_init                (sec_read_init),
   .pri_data_perr                (pri_data_perr),
   .sec_data_perr                (sec_data_perr),
   .pri_mdpd                     (pri_mdpd),
   .sec_mdpd                     (sec_mdpd),
   .primary_parity_error_n_out   (primary_parity_error_n_out),
   .primary_parity_error_n_oe    (primary_parity_error_n_oe),
   .secondary_parity_error_n_out (secondary_parity_error_n_out),
   .secondary_parity_error_n_oe  (secondary_parity_error_n_oe)
);

// File: bdpr_far.sv
/*
 Far-side agents on one parity error line, with the line's pull-up.
 Assumes the bench commands when a far target reports an error.
*/
`timescale 1ns/1ps
`default_nettype none
module bdpr_far (
   // Bridge driver
   input  wire logic drv_n,
   input  wire logic drv_oe,
   // Far agent report command
   input  wire logic far_report,
   // Resolved line level
   output logic      line_n
);
   // Wired line: any puller wins, pull-up otherwise
   assign line_n = ~(far_report | (drv_oe & ~drv_n));
endmodule
`default_nettype wire

// File: testbench.sv
/*
 Self-checking bench for bdpr_top with far agents on both lines.
 Assumes the bind in the checker file; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bdpr_pkg::*;
   // Clock, reset and core-side inputs
   logic mclk = 1'b0, reset_n = 1'b0;
   logic pri_perr_resp_en, pri_master, pri_write_target, pri_read_init;
   logic sec_perr_resp_en, sec_master, sec_write_target, sec_read_init;
   logic pri_data_perr, pri_dly_wr_done, pri_mdpd_clear, pri_mdpd;
   logic sec_data_perr, sec_dly_wr_done, sec_mdpd_clear, sec_mdpd;
   // Pins: p_ primary, s_ secondary
   logic p_in, p_out, p_oe, p_far, s_in, s_out, s_oe, s_far;
   int   n_mismatch = 0, num_checks = 0;
   // Rows: pri en,mst,wr,rd,det; sec same; pmdpd,smdpd,plow,slow
   logic [13:0] rows [7] = '{14'h3298, 14'h1394, 14'h2B33, 14'h2652,
                             14'h0B51, 14'h31E0, 14'h3FFF};
   always #12.5 mclk = ~mclk;
   bdpr_top bdpr_top_inst (.mclk, .reset_n, .pri_perr_resp_en,
      .sec_perr_resp_en, .pri_master, .pri_write_target, .pri_read_init,
      .pri_data_perr, .pri_dly_wr_done, .sec_master, .sec_write_target,
      .sec_read_init, .sec_data_perr, .sec_dly_wr_done, .pri_mdpd_clear,
      .sec_mdpd_clear, .pri_mdpd, .sec_mdpd,
      .primary_parity_error_n_in(p_in), .primary_parity_error_n_out(p_out),
      .primary_parity_error_n_oe(p_oe), .secondary_parity_error_n_in(s_in),
      .secondary_parity_error_n_out(s_out),
      .secondary_parity_error_n_oe(s_oe));
   bdpr_far far_pri (.drv_n(p_out), .drv_oe(p_oe), .far_report(p_far),
      .line_n(p_in));
   bdpr_far far_sec (.drv_n(s_out), .drv_oe(s_oe), .far_report(s_far),
      .line_n(s_in));
   //////////////////////////////////////////////////////////////
   task automatic chk(string what, logic seen, logic exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Far target pulls the line low while we are master
   task automatic pin_case(logic en);
      {pri_perr_resp_en, pri_master} = {en, 1'b1};
      {sec_perr_resp_en, sec_master} = {en, 1'b1};
      {p_far, s_far} = 2'b11;
      cyc(2);
      {p_far, s_far} = 2'b00;
      cyc(3);
      chk("pri_pin", pri_mdpd, en);
      chk("sec_pin", sec_mdpd, en);
      {pri_master, sec_master, pri_mdpd_clear, sec_mdpd_clear} = 4'h3;
      cyc(1);
      {pri_mdpd_clear, sec_mdpd_clear} = 2'h0;
   endtask
   // Other line low while a delayed write completes: forward
   task automatic fwd_case(logic to_sec);
      logic seen;
      seen = 1'b0;
      {pri_write_target, sec_write_target} = 2'h3;
      {pri_dly_wr_done, sec_dly_wr_done, p_far, s_far} = {2{to_sec, ~to_sec}};
      repeat (5) begin
         cyc(1);
         seen |= to_sec ? (s_oe & ~s_out) : (p_oe & ~p_out);
      end
      chk("fwd", seen, 1'b1);
      {pri_write_target, sec_write_target, p_far, s_far} = 4'h0;
      {pri_dly_wr_done, sec_dly_wr_done} = 2'h0;
      cyc(4);
   endtask
   // Set and clear in one cycle: set wins; then a reset in mid-run
   task automatic set_clr_case();
      {pri_perr_resp_en, pri_master, pri_read_init} = 3'h7;
      {pri_data_perr, pri_mdpd_clear} = 2'h3;
      cyc(1);
      chk("set_wins", pri_mdpd, 1'b1);
      chk("mid_low", p_in, 1'b0);
      reset_n = 1'b0;
      {pri_perr_resp_en, pri_master, pri_read_init} = 3'h0;
      {pri_data_perr, pri_mdpd_clear} = 2'h0;
      cyc(1);
      chk("mid_rst_mdpd", pri_mdpd, 1'b0);
      chk("mid_rst_oe", p_oe, 1'b0);
      reset_n = 1'b1;
      cyc(2);
      chk("post_rst_oe", p_oe, 1'b0);
      chk("post_rst_line", p_in, 1'b1);
   endtask
   initial begin
      {pri_perr_resp_en, pri_master, pri_write_target, pri_read_init} = 4'h0;
      {sec_perr_resp_en, sec_master, sec_write_target, sec_read_init} = 4'h0;
      {pri_data_perr, pri_dly_wr_done, pri_mdpd_clear, p_far} = 4'h0;
      {sec_data_perr, sec_dly_wr_done, sec_mdpd_clear, s_far} = 4'h0;
      repeat (6) @(posedge mclk);
      cyc(1);
      reset_n = 1'b1;
      chk("rst_pri_mdpd", pri_mdpd, 1'b0);
      chk("rst_p_oe", p_oe, 1'b0);
      chk("rst_s_line", s_in, 1'b1);
      foreach (rows[i]) begin
         {pri_perr_resp_en, pri_master, pri_write_target, pri_read_init,
          pri_data_perr, sec_perr_resp_en, sec_master, sec_write_target,
          sec_read_init, sec_data_perr} = rows[i][13:4];
         cyc(1);
         chk("pri_mdpd", pri_mdpd, rows[i][3]);
         chk("sec_mdpd", sec_mdpd, rows[i][2]);
         chk("p_low", ~p_in, rows[i][1]);
         chk("s_low", ~s_in, rows[i][0]);
         {pri_master, pri_write_target, pri_read_init, pri_data_perr} = 4'h0;
         {sec_master, sec_write_target, sec_read_init, sec_data_perr} = 4'h0;
         {pri_mdpd_clear, sec_mdpd_clear} = 2'h3;
         cyc(1);
         {pri_mdpd_clear, sec_mdpd_clear} = 2'h0;
         chk("p_park", p_oe, rows[i][1]);
         chk("s_high", s_in, 1'b1);
         cyc(1);
         chk("p_rel", p_oe, 1'b0);
         chk("pri_clr", pri_mdpd, 1'b0);
      end
      pin_case(1'b0);
      pin_case(1'b1);
      {pri_perr_resp_en, sec_perr_resp_en} = 2'h3;
      fwd_case(1'b0);
      fwd_case(1'b1);
      set_clr_case();
      finish_test();
   end
   // Watchdog, well beyond the 62 or so cycles needed
   initial begin
      #20us;
      n_mismatch++;
      finish_test();
   end
endmodule
`default_nettype wire
